// [iis_pkg.sv]
// Constants, types and register map of the interrupt status block
// How it works
// (RQ1) Arbitration loss sets raw bit 24
// (RQ2) Arbitration loss or bus error loads tag
// (RQ3) Released-high data sampled low means collision
// (RQ4) After collision release bus, await stop, retry
// (RQ5) First unique zero driver wins arbitration
// (RQ6) Unexpected start/stop sets bit 25, reaction varies
// (RQ7) Master done without stop request sets bit 28
// (RQ8) Software reads status, drains, then clears event
// (RQ9) New master command only after bit 28 clear
// (RQ10) Bit 28 pending holds clock, defers requests
// (RQ11) Raw sticky bits clear only via clear register; bit 16 also clears on a tx write
// (RQ12) Masked register bits 0-6 show FIFO events
// (RQ13) Bit 1: tx count at most threshold
// (RQ14) Bit 5: rx count at least threshold
// (RQ15) Bit 2 tx full, bit 3 tx overrun
// (RQ16) Bit 4 rx empty, bit 6 rx full
// (RQ17) Bits 16-20 target and done events
// (RQ18) Masked is raw AND enable; OR drives interrupt
// (RQ19) Clear bit 1 clears, 0 leaves event
package iis_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0]  MCMD_OFFSET   = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET = 8'h10;
  localparam logic [7:0]  THR_OFFSET    = 8'h20;
  localparam logic [7:0]  RAW_OFFSET    = 8'h30;
  localparam logic [7:0]  MASKED_OFFSET = 8'h34;
  localparam logic [7:0]  CLEAR_OFFSET  = 8'h38;
  localparam logic [7:0]  ENABLE_OFFSET = 8'h3c;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_TXFE    = 0;
  localparam int BIT_TXFNE   = 1;
  localparam int BIT_TXFF    = 2;
  localparam int BIT_TXOVR   = 3;
  localparam int BIT_RXFE    = 4;
  localparam int BIT_RXFNF   = 5;
  localparam int BIT_RXFF    = 6;
  localparam int BIT_READ_FROM_TARGET_REQUEST    = 16;
  localparam int BIT_RFSE    = 17;
  localparam int BIT_WRITE_TO_TARGET_REQUEST    = 18;
  localparam int BIT_MTD     = 19;
  localparam int BIT_STD     = 20;
  localparam int BIT_ARBLOST = 24;
  localparam int BIT_BFAULT  = 25;
  localparam int BIT_MASTER_DONE_NO_STOP_FLAG   = 28;
  localparam int MCMD_START  = 0;
  localparam int MCMD_STOP   = 1;
  localparam int SR_REFUSED  = 4;
  localparam int THR_TX_LSB  = 0;
  localparam int THR_RX_LSB  = 8;

  // Bits held until software clears them, bit 16 also on a tx write; the rest follow live levels
  localparam logic [31:0] STICKY_MASK  = 32'h131d0008;
  localparam logic [31:0] ENABLE_RESET = 32'h00000000;
  localparam logic [4:0]  TXTHR_RESET  = 5'h00;
  localparam logic [4:0]  RXTHR_RESET  = 5'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    TAG_NONE        = 4'h0,
    TAG_ARB_LOST    = 4'h1,
    TAG_BUS_FAULT_FLAG_MASTER = 4'h2,
    TAG_BUS_FAULT_FLAG_TARGET = 4'h3
  } iis_tag_t;

  typedef enum logic [0:0] {
    ARB_NORMAL    = 1'b0,
    ARB_WAIT_STOP = 1'b1
  } iis_arb_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } iis_bus_req_t;

  // Event and status signals from the serial engine, same clock
  typedef struct packed {
    logic master_done;
    logic tgt_read_req;
    logic tgt_write_req;
    logic tgt_read_empty;
    logic tgt_done;
    logic tx_overrun;
    logic tx_write;
    logic in_transfer;
    logic master_op;
    logic transmitting;
    logic tx_bit;
  } iis_core_ev_t;

endpackage : iis_pkg

// [iis_top.sv]
// Interrupt status, arbitration watch and bus fault logic
`timescale 1ns/10ps
`default_nettype none

module iis_top #(
  parameter int CNT_W   = 5,
  parameter int DEPTH   = 16
) (
  // Clock and reset
  input  wire logic               mclk_i,
  input  wire logic               arst_n_i,
  // Register port
  input  wire iis_pkg::iis_bus_req_t bus_i,
  output logic [31:0]             rdata_o,
  // Serial engine events and FIFO levels
  input  wire iis_pkg::iis_core_ev_t ev_i,
  input  wire logic [CNT_W-1:0]   tx_count_i,
  input  wire logic [CNT_W-1:0]   rx_count_i,
  // Bus pins, sampled
  input  wire logic               sda_i,
  input  wire logic               scl_i,
  // Serial engine control and interrupt
  output logic                    start_o,
  output logic                    stop_req_o,
  output logic                    retry_o,
  output logic                    release_o,
  output logic                    abort_o,
  output logic                    scl_hold_o,
  output logic                    irq_o
);
  import iis_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [31:0]  raw;
    logic [31:0]  enable;
    logic [4:0]   tx_thr;
    logic [4:0]   rx_thr;
    iis_tag_t     tag;
    logic         refused;
    logic         stop_req;
    logic         start;
    logic         retry;
    logic         abort;
    iis_arb_t     arb;
    logic         def_read_from_target_request;
    logic         def_write_to_target_request;
    logic [1:0]   sda_sh;
    logic [1:0]   scl_sh;
    logic         sda_prev;
    logic         scl_prev;
    logic [31:0]  rdata;
  } iis_state_t;

  iis_state_t st;
  iis_state_t next_st;

  logic        sda_s;
  logic        scl_s;
  logic        scl_rise;
  logic        start_det;
  logic        stop_det;
  logic        collision;
  logic        bus_fault;
  logic        wr_mcmd;
  logic        wr_clear;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic [31:0] level_vec;
  logic [31:0] masked;
  logic        hold;

  assign sda_s     = st.sda_sh[1];
  assign scl_s     = st.scl_sh[1];
  assign scl_rise  = scl_s && !st.scl_prev;
  // Start and stop are data edges while the clock stays high
  assign start_det = scl_s && st.scl_prev && st.sda_prev && !sda_s;
  assign stop_det  = scl_s && st.scl_prev && !st.sda_prev && sda_s;
  // A station sending a one only releases the line; a low read back
  // means another station drives a unique zero and has won
  assign collision = ev_i.transmitting && ev_i.tx_bit && scl_rise
                     && !sda_s && (st.arb == ARB_NORMAL); // RQ3 RQ5
  assign bus_fault = (start_det || stop_det) && ev_i.in_transfer; // RQ6
  assign wr_mcmd   = bus_i.wr && (bus_i.addr == MCMD_OFFSET);
  assign wr_clear  = bus_i.wr && (bus_i.addr == CLEAR_OFFSET);
  assign masked    = st.raw & st.enable; // RQ18
  assign hold      = st.raw[BIT_MASTER_DONE_NO_STOP_FLAG];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.sda_sh = {st.sda_sh[0], sda_i};
    next_st.scl_sh = {st.scl_sh[0], scl_i};
    next_st.sda_prev = sda_s;
    next_st.scl_prev = scl_s;
    next_st.start = 1'b0;
    next_st.retry = 1'b0;
    next_st.abort = 1'b0;

    // Live FIFO levels, refreshed every cycle
    level_vec = 32'h0;
    level_vec[BIT_TXFE]  = (tx_count_i == '0);
    level_vec[BIT_TXFNE] = (tx_count_i <= st.tx_thr[CNT_W-1:0]); // RQ13
    level_vec[BIT_TXFF]  = (tx_count_i == CNT_W'(DEPTH)); // RQ15
    level_vec[BIT_RXFE]  = (rx_count_i == '0); // RQ16
    level_vec[BIT_RXFNF] = (rx_count_i >= st.rx_thr[CNT_W-1:0]); // RQ14
    level_vec[BIT_RXFF]  = (rx_count_i == CNT_W'(DEPTH)); // RQ16
    level_vec[BIT_RFSE]  = ev_i.tgt_read_empty; // RQ17

    set_vec = 32'h0;
    set_vec[BIT_TXOVR]   = ev_i.tx_overrun; // RQ15
    set_vec[BIT_STD]     = ev_i.tgt_done; // RQ17
    set_vec[BIT_ARBLOST] = collision; // RQ1
    set_vec[BIT_BFAULT]  = bus_fault; // RQ6
    if (ev_i.master_done) begin
      if (st.stop_req) begin
        set_vec[BIT_MTD] = 1'b1; // RQ17
      end else begin
        set_vec[BIT_MASTER_DONE_NO_STOP_FLAG] = 1'b1; // RQ7
      end
    end

    // Target requests wait while a no-stop completion is unacknowledged
    if (hold) begin
      next_st.def_read_from_target_request = st.def_read_from_target_request || ev_i.tgt_read_req; // RQ10
      next_st.def_write_to_target_request = st.def_write_to_target_request || ev_i.tgt_write_req; // RQ10
    end else begin
      set_vec[BIT_READ_FROM_TARGET_REQUEST] = st.def_read_from_target_request || ev_i.tgt_read_req; // RQ17
      set_vec[BIT_WRITE_TO_TARGET_REQUEST] = st.def_write_to_target_request || ev_i.tgt_write_req; // RQ17
      next_st.def_read_from_target_request = 1'b0;
      next_st.def_write_to_target_request = 1'b0;
    end

    // Only ones clear, and a set in the same cycle wins
    clr_vec = 32'h0;
    if (wr_clear) begin
      clr_vec = bus_i.wdata & STICKY_MASK; // RQ11 RQ19
    end
    if (ev_i.tx_write) begin
      clr_vec[BIT_READ_FROM_TARGET_REQUEST] = 1'b1;
    end
    next_st.raw = (((st.raw & STICKY_MASK) & ~clr_vec) | set_vec)
                  & STICKY_MASK | level_vec; // RQ11

    // Error tag: arbitration first, then bus fault by operation kind
    if (collision) begin
      next_st.tag = TAG_ARB_LOST; // RQ2
    end else if (bus_fault) begin
      next_st.tag = ev_i.master_op ? TAG_BUS_FAULT_FLAG_MASTER
                                   : TAG_BUS_FAULT_FLAG_TARGET; // RQ2 RQ6
    end

    // Fault aborts the operation in progress
    next_st.abort = bus_fault; // RQ6

    // Arbitration loss: release and wait for the bus to go idle
    unique case (st.arb)
      ARB_NORMAL: begin
        if (collision) begin
          next_st.arb = ARB_WAIT_STOP; // RQ4
        end
      end
      ARB_WAIT_STOP: begin
        if (stop_det) begin
          next_st.arb = ARB_NORMAL;
          next_st.retry = 1'b1; // RQ4
        end
      end
    endcase

    // Registers
    if (wr_mcmd && bus_i.wdata[MCMD_START]) begin
      if (hold || st.arb == ARB_WAIT_STOP) begin
        next_st.refused = 1'b1; // RQ9
      end else begin
        next_st.refused = 1'b0;
        next_st.start = 1'b1; // RQ9
        next_st.stop_req = bus_i.wdata[MCMD_STOP]; // RQ7
      end
    end
    if (bus_i.wr && bus_i.addr == THR_OFFSET) begin
      next_st.tx_thr = bus_i.wdata[THR_TX_LSB +: 5];
      next_st.rx_thr = bus_i.wdata[THR_RX_LSB +: 5];
    end
    if (bus_i.wr && bus_i.addr == ENABLE_OFFSET) begin
      next_st.enable = bus_i.wdata & (STICKY_MASK | 32'h0002007f);
    end

    next_st.rdata = 32'h0;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        MCMD_OFFSET:   next_st.rdata = {30'h0, st.stop_req, 1'b0};
        STATUS_OFFSET: next_st.rdata = {27'h0, st.refused, st.tag};
        THR_OFFSET:    next_st.rdata = {19'h0, st.rx_thr, 3'h0, st.tx_thr};
        RAW_OFFSET:    next_st.rdata = st.raw;
        MASKED_OFFSET: next_st.rdata = masked; // RQ12 RQ18
        ENABLE_OFFSET: next_st.rdata = st.enable;
        default:       next_st.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st        <= '0;
      st.enable <= ENABLE_RESET;
      st.tx_thr <= TXTHR_RESET;
      st.rx_thr <= RXTHR_RESET;
      st.tag    <= TAG_NONE;
      st.arb    <= ARB_NORMAL;
      st.sda_sh <= 2'h3;
      st.scl_sh <= 2'h3;
      st.sda_prev <= 1'b1;
      st.scl_prev <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rdata_o    = st.rdata;
  assign start_o    = st.start;
  assign stop_req_o = st.stop_req;
  assign retry_o    = st.retry;
  assign release_o  = (st.arb == ARB_WAIT_STOP); // RQ4
  assign abort_o    = st.abort;
  assign scl_hold_o = hold; // RQ10
  assign irq_o      = |masked; // RQ18

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_collision;
    collision;
  endsequence

  sequence s_wait_then_stop;
    (st.arb == ARB_WAIT_STOP) ##0 stop_det;
  endsequence

  a_arb_sets_flag: assert property (s_collision |=> st.raw[24]) // RQ1
    else $error("arbitration loss did not set raw bit 24");

  a_arb_tag_load: assert property (s_collision |=> st.tag == TAG_ARB_LOST) // RQ2
    else $error("arbitration loss tag not loaded");

  // Retry and the return to normal land on one edge, so the release
  // must hold up to the retry cycle but not in it
  a_collision_release: assert property ( // RQ4
    s_collision |=> release_o until retry_o)
    else $error("bus not released after collision");

  a_retry_on_stop: assert property (
    s_wait_then_stop |=> retry_o ##1 !retry_o && !release_o) // RQ4
    else $error("no single retry after stop");

  a_fault_flag_tag: assert property (bus_fault |=> st.raw[25] && abort_o
    && st.tag == ($past(ev_i.master_op) ? TAG_BUS_FAULT_FLAG_MASTER
                                        : TAG_BUS_FAULT_FLAG_TARGET)) // RQ6
    else $error("bus fault not flagged");

  a_nostop_flag: assert property (
    ev_i.master_done && !st.stop_req |=> st.raw[28] && scl_hold_o) // RQ7
    else $error("no-stop completion not flagged");

  a_cmd_refused: assert property (
    wr_mcmd && bus_i.wdata[0] && hold |=> !start_o && st.refused) // RQ9
    else $error("command accepted while completion pending");

  a_req_deferred: assert property (
    hold && ev_i.tgt_write_req && !st.raw[18] && !st.def_write_to_target_request
    |=> !st.raw[18] && st.def_write_to_target_request) // RQ10
    else $error("target request not deferred");

  a_sticky_holds: assert property (
    st.raw[24] && !(wr_clear && bus_i.wdata[24]) |=> st.raw[24]) // RQ11
    else $error("raw bit 24 dropped without clear");

  a_clear_bit: assert property (
    wr_clear && bus_i.wdata[28] && !ev_i.master_done |=> !st.raw[28]) // RQ19
    else $error("clear write did not clear bit 28");

  // Level bits are still zero at the edge that leaves reset
  a_tx_low_level: assert property ($past(arst_n_i) |-> // RQ13
    st.raw[1] == ($past(tx_count_i) <= $past(st.tx_thr[CNT_W-1:0])))
    else $error("tx low level wrong");

  a_rx_high_level: assert property ($past(arst_n_i) |-> // RQ14
    st.raw[5] == ($past(rx_count_i) >= $past(st.rx_thr[CNT_W-1:0])))
    else $error("rx high level wrong");

  a_masked_read: assert property (bus_i.rd && bus_i.addr == MASKED_OFFSET
    |=> rdata_o == $past(st.raw & st.enable)) // RQ12
    else $error("masked register read wrong");

  a_irq_level: assert property ( // RQ18
    irq_o == ((st.raw & st.enable) != 32'h0))
    else $error("interrupt line wrong");

endmodule : iis_top

`default_nettype wire

// [iis_peer.sv]
// Model of another station on the two-wire bus
`timescale 1ns/10ps
`default_nettype none

module iis_peer (
  // Clock
  input  wire logic mclk_i,
  // Bus lines; released lines sit at the pull-up level
  output logic      scl_o,
  output logic      sda_o
);
  // Slow enough to clear the pin synchronisers in the block
  localparam int PH = 6;

  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic step(input logic c, input logic d);
    @(posedge mclk_i);
    scl_o <= c;
    sda_o <= d;
    repeat (PH) @(posedge mclk_i);
  endtask : step

  // Data changes only while the clock is low; the clock stands high after
  task automatic send_bit(input logic v);
    step(1'b0, sda_o);
    step(1'b0, v);
    step(1'b1, v);
  endtask : send_bit

  task automatic start_cond();
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask : start_cond

  // Returns the bus to idle, both lines released
  task automatic stop_cond();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask : stop_cond
endmodule : iis_peer
`default_nettype wire

// [test_i2c_interrupt_status.sv]
// Self-checking bench of the interrupt status block
`timescale 1ns/10ps
`default_nettype none

module test_i2c_interrupt_status;
  import iis_pkg::*;
  localparam int          DEPTH = 16;
  localparam logic [31:0] EN_W  = 32'h131f007f;
  logic         mclk_i;
  logic         arst_n_i;
  iis_bus_req_t bus;
  iis_core_ev_t ev;
  logic [4:0]   txc;
  logic [4:0]   rxc;
  wire          scl;
  wire          sda;
  logic [31:0]  rdata_o;
  logic         start_o;
  logic         stop_req_o;
  logic         retry_o;
  logic         release_o;
  logic         abort_o;
  logic         scl_hold_o;
  logic         irq_o;
  logic [31:0]  q;
  logic [31:0]  e;
  logic [31:0]  base;
  int           mismatches;
  int           comparisons;
  int           n_abort;
  int           n_retry;
  int           t;
  int           r;
  int           tt;
  int           rt;
  int           sb [3] = '{BIT_TXOVR, BIT_READ_FROM_TARGET_REQUEST, BIT_STD};

  iis_top #(.CNT_W(5), .DEPTH(DEPTH)) u_dut (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .bus_i(bus), .rdata_o(rdata_o),
    .ev_i(ev), .tx_count_i(txc), .rx_count_i(rxc), .sda_i(sda),
    .scl_i(scl), .start_o(start_o), .stop_req_o(stop_req_o),
    .retry_o(retry_o), .release_o(release_o), .abort_o(abort_o),
    .scl_hold_o(scl_hold_o), .irq_o(irq_o));

  iis_peer u_peer (.mclk_i(mclk_i), .scl_o(scl), .sda_o(sda));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] lvl(int tc, int rc_, int th, int rh);
    lvl = 32'h0;
    lvl[BIT_TXFE]  = (tc == 0);
    lvl[BIT_TXFNE] = (tc <= th);
    lvl[BIT_TXFF]  = (tc == DEPTH);
    lvl[BIT_RXFE]  = (rc_ == 0);
    lvl[BIT_RXFNF] = (rc_ >= rh);
    lvl[BIT_RXFF]  = (rc_ == DEPTH);
  endfunction : lvl

  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge mclk_i);
    bus.wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rc(input string n, input logic [7:0] a,
                    input logic [31:0] x);
    @(posedge mclk_i);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge mclk_i);
    bus.rd <= 1'b0;
    #1 q = rdata_o;
    chk(n, x, q);
  endtask : rc

  task automatic pulse(input int k);
    @(posedge mclk_i);
    ev.tx_overrun    <= (k == 0);
    ev.tgt_read_req  <= (k == 1);
    ev.tgt_done      <= (k == 2);
    ev.master_done   <= (k == 3);
    ev.tgt_write_req <= (k == 4);
    ev.tx_write      <= (k == 5);
    @(posedge mclk_i);
    ev.tx_overrun    <= 1'b0;
    ev.tgt_read_req  <= 1'b0;
    ev.tgt_done      <= 1'b0;
    ev.master_done   <= 1'b0;
    ev.tgt_write_req <= 1'b0;
    ev.tx_write      <= 1'b0;
    #1;
  endtask : pulse

  task automatic finish_test();
    if (mismatches == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  // Output pulses are counted here so no scenario has to poll for them
  always @(posedge mclk_i) begin
    if (abort_o === 1'b1) n_abort++;
    if (retry_o === 1'b1) n_retry++;
  end

  initial begin
    #1000000;
    mismatches++;
    finish_test();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    arst_n_i = 1'b0;
    bus = '0;
    ev = '0;
    txc = 5'h0;
    rxc = 5'h0;
    mismatches = 0;
    comparisons = 0;
    n_abort = 0;
    n_retry = 0;
    void'($urandom(32'h25a3));
    repeat (4) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    base = lvl(0, 0, 0, 0);
    rc("raw", RAW_OFFSET, base);
    rc("masked", MASKED_OFFSET, 32'h0);
    rc("enable", ENABLE_OFFSET, ENABLE_RESET);
    rc("unmapped", 8'h44, 32'h0);
    rc("clear", CLEAR_OFFSET, 32'h0);
    chk("irq", 32'h0, irq_o);
    wr(ENABLE_OFFSET, 32'hffffffff);
    rc("enable", ENABLE_OFFSET, EN_W);
    for (int i = 0; i < 24; i++) begin
      t = $urandom_range(DEPTH, 0);
      r = $urandom_range(DEPTH, 0);
      tt = $urandom_range(31, 0);
      rt = $urandom_range(31, 0);
      if (i == 0) begin
        t = 7; tt = 7; r = 9; rt = 9;
      end
      if (i == 1) begin
        t = DEPTH; r = DEPTH; tt = 15; rt = 17;
      end
      txc <= t[4:0];
      rxc <= r[4:0];
      ev.tgt_read_empty <= i[0];
      wr(THR_OFFSET, {19'h0, rt[4:0], 3'h0, tt[4:0]});
      rc("thr", THR_OFFSET, {19'h0, rt[4:0], 3'h0, tt[4:0]});
      e = lvl(t, r, tt, rt);
      e[BIT_RFSE] = i[0];
      rc("masked", MASKED_OFFSET, e);
      chk("irq", {31'h0, |e}, irq_o);
    end
    txc <= 5'h0;
    rxc <= 5'h0;
    ev.tgt_read_empty <= 1'b0;
    wr(THR_OFFSET, 32'h0);
    for (int i = 0; i < 3; i++) begin
      pulse(i);
      rc("raw", RAW_OFFSET, base | (32'h1 << sb[i]));
      wr(CLEAR_OFFSET, 32'h1 << sb[i]);
      rc("raw", RAW_OFFSET, base);
    end
    // A write into the transmit FIFO serves a pending read request
    pulse(1);
    rc("raw", RAW_OFFSET, base | 32'h00010000);
    pulse(5);
    rc("raw", RAW_OFFSET, base);
    // Completion without stop blocks commands and target requests
    wr(MCMD_OFFSET, 32'h1);
    chk("start", 32'h1, start_o);
    chk("stop_req", 32'h0, stop_req_o);
    pulse(3);
    chk("scl_hold", 32'h1, scl_hold_o);
    wr(MCMD_OFFSET, 32'h1);
    chk("start", 32'h0, start_o);
    rc("status", STATUS_OFFSET, 32'h10);
    pulse(4);
    wr(CLEAR_OFFSET, 32'hefffffff);
    rc("raw", RAW_OFFSET, base | 32'h10000000);
    wr(CLEAR_OFFSET, 32'h10000000);
    rc("raw", RAW_OFFSET, base | 32'h00040000);
    chk("scl_hold", 32'h0, scl_hold_o);
    wr(MCMD_OFFSET, 32'h3);
    chk("start", 32'h1, start_o);
    chk("stop_req", 32'h1, stop_req_o);
    rc("mcmd", MCMD_OFFSET, 32'h2);
    pulse(3);
    rc("raw", RAW_OFFSET, base | 32'h000c0000);
    wr(CLEAR_OFFSET, 32'h000c0000);
    // Collision: one sent, the other station pulls the line low
    ev.transmitting <= 1'b1;
    ev.tx_bit <= 1'b1;
    u_peer.send_bit(1'b0);
    repeat (4) @(posedge mclk_i);
    ev.transmitting <= 1'b0;
    rc("raw", RAW_OFFSET, base | 32'h01000000);
    rc("status", STATUS_OFFSET, {28'h0, TAG_ARB_LOST});
    chk("release", 32'h1, release_o);
    wr(MCMD_OFFSET, 32'h1);
    chk("start", 32'h0, start_o);
    u_peer.stop_cond();
    repeat (4) @(posedge mclk_i);
    chk("retry", 32'h1, n_retry);
    chk("release", 32'h0, release_o);
    wr(CLEAR_OFFSET, 32'h01000000);
    rc("raw", RAW_OFFSET, base);
    // Start and stop inside a transfer, master then target
    ev.in_transfer <= 1'b1;
    ev.master_op <= 1'b1;
    u_peer.start_cond();
    repeat (4) @(posedge mclk_i);
    chk("abort", 32'h1, n_abort);
    // The refused command during the collision wait is still reported
    rc("status", STATUS_OFFSET, {27'h0, 1'b1, TAG_BUS_FAULT_FLAG_MASTER});
    ev.master_op <= 1'b0;
    u_peer.stop_cond();
    repeat (4) @(posedge mclk_i);
    ev.in_transfer <= 1'b0;
    chk("abort", 32'h2, n_abort);
    rc("status", STATUS_OFFSET, {27'h0, 1'b1, TAG_BUS_FAULT_FLAG_TARGET});
    rc("raw", RAW_OFFSET, base | 32'h02000000);
    wr(CLEAR_OFFSET, 32'h02000000);
    // Interrupt line follows only enabled bits
    wr(ENABLE_OFFSET, 32'h0);
    pulse(0);
    chk("irq", 32'h0, irq_o);
    wr(ENABLE_OFFSET, 32'h8);
    chk("irq", 32'h1, irq_o);
    rc("masked", MASKED_OFFSET, 32'h8);
    wr(CLEAR_OFFSET, 32'h8);
    chk("irq", 32'h0, irq_o);
    finish_test();
  end
endmodule : test_i2c_interrupt_status
`default_nettype wire
